// ===== common/pmcc_pkg.sv
// Shared constants and types of the power mode clock controller
`default_nettype none
package pmcc_pkg;

  // Register byte offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_SETTLE = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;

  // Control register field positions
  localparam int CTRL_MULT_LSB = 0;
  localparam int CTRL_MULT_W = 5;
  localparam int CTRL_BYPASS_BIT = 5;
  localparam int CTRL_SSEL_LSB = 6;
  localparam int CTRL_REQ_LSB = 8;
  localparam int SETTLE_W = 16;

  // Status register field positions
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_LOCK_BIT = 8;
  localparam int STAT_DMA_BIT = 9;
  localparam int STAT_MULT_LSB = 16;
  localparam int STAT_SSEL_LSB = 24;

  // Reset values
  localparam logic [4:0] MULT_RESET = 5'h01;
  localparam logic [15:0] SETTLE_RESET = 16'h0200;

  // Cycles to let the strap synchronisers fill after reset release
  localparam logic [1:0] BOOT_WAIT = 2'h3;

  // Requested target of the next idle
  localparam logic [1:0] REQ_RUN = 2'h0;
  localparam logic [1:0] REQ_RELAX = 2'h1;
  localparam logic [1:0] REQ_SLEEP = 2'h2;
  localparam logic [1:0] REQ_DEEP = 2'h3;

  // Operating modes, one-hot
  typedef enum logic [5:0] {
    MODE_BOOT = 6'h01,
    MODE_FULL = 6'h02,
    MODE_ACTIVE = 6'h04,
    MODE_RELAXED = 6'h08,
    MODE_SLEEP = 6'h10,
    MODE_DEEP = 6'h20
  } pmcc_mode_type;

  // Clock gating configuration handed to the divider
  typedef struct packed {
    logic coreRun;
    logic sysRun;
    logic halfRate;
    logic [1:0] ratioSel;
  } pmcc_clk_cfg_type;

  // Core-to-system ratio in half core periods: 2, 2.5, 3, 4
  function automatic logic [3:0] ratio_half_steps(input logic [1:0] sel);
    case (sel)
      2'h0: ratio_half_steps = 4'h4;
      2'h1: ratio_half_steps = 4'h5;
      2'h2: ratio_half_steps = 4'h6;
      default: ratio_half_steps = 4'h8;
    endcase
  endfunction

endpackage
`default_nettype wire

// ===== logic/pmcc_clk_divider.sv
// Core and system clock enable generator with glitch-free gating
`timescale 1ns/1ps
`default_nettype none
module pmcc_clk_divider (
  input wire logic clk,
  input wire logic rst,
  input wire pmcc_pkg::pmcc_clk_cfg_type cfgIn,
  output logic coreTick,
  output logic sysTick
);

  pmcc_pkg::pmcc_clk_cfg_type cfg_q, cfg_d;
  logic halfPh_q, halfPh_d;
  logic [3:0] acc_q, acc_d;
  logic coreTick_q, coreTick_d;
  logic sysTick_q, sysTick_d;
  logic baseTick;
  logic [3:0] accNext;
  logic [3:0] thr;

  always_comb begin
    thr = pmcc_pkg::ratio_half_steps(cfg_q.ratioSel);
    halfPh_d = ~halfPh_q;
    baseTick = ~cfg_q.halfRate | halfPh_q;
    accNext = acc_q + 4'h2;
    acc_d = acc_q;
    sysTick_d = 1'b0;
    if (baseTick) begin
      if (accNext >= thr) begin
        acc_d = accNext - thr;
        sysTick_d = cfg_q.sysRun;
      end else begin
        acc_d = accNext;
      end
    end
    coreTick_d = baseTick & cfg_q.coreRun;
    // New gating only at a whole system period boundary
    cfg_d = cfg_q;
    if (acc_q == 4'h0 && (!halfPh_q || !cfg_q.halfRate)) begin
      cfg_d = cfgIn;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= '0;
      halfPh_q <= 1'b0;
      acc_q <= 4'h0;
      coreTick_q <= 1'b0;
      sysTick_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      halfPh_q <= halfPh_d;
      acc_q <= acc_d;
      coreTick_q <= coreTick_d;
      sysTick_q <= sysTick_d;
    end
  end

  assign coreTick = coreTick_q;
  assign sysTick = sysTick_q;

endmodule // pmcc_clk_divider
`default_nettype wire

// ===== logic/power_mode_clock_controller.sv
// Operating mode, PLL and clock gating controller with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
module power_mode_clock_controller #(
  parameter logic [4:0] MULT_DEFAULT = pmcc_pkg::MULT_RESET,
  parameter logic [15:0] SETTLE_DEFAULT = pmcc_pkg::SETTLE_RESET
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bypassPin,
  input wire logic [1:0] sselStrapPin,
  input wire logic irqAny,
  input wire logic rtcWakeIrq,
  input wire logic coreIdleReq,
  input wire logic sysAck,
  output logic idleOut,
  output logic coreClkEn,
  output logic sysClkEn,
  output logic pllEnable,
  output logic pllBypass,
  output logic [4:0] pllMult,
  output logic dmaL1Allowed,
  output logic regulatorOk
);

  initial begin
    if (SETTLE_DEFAULT == 16'h0000) begin
      $error("SETTLE_DEFAULT must be nonzero");
    end
    if (MULT_DEFAULT == 5'h00) begin
      $error("MULT_DEFAULT must be nonzero");
    end
  end

  // Pin synchronisers: bypass, strap[1:0], interrupt, rtc wake
  logic [4:0] pinSync1_q, pinSync2_q;
  logic bypassS, irqS, rtcS;
  logic [1:0] sselS;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinSync1_q <= 5'h00;
      pinSync2_q <= 5'h00;
    end else begin
      pinSync1_q <= {rtcWakeIrq, irqAny, sselStrapPin, bypassPin};
      pinSync2_q <= pinSync1_q;
    end
  end

  assign bypassS = pinSync2_q[0];
  assign sselS = pinSync2_q[2:1];
  assign irqS = pinSync2_q[3];
  assign rtcS = pinSync2_q[4];

  // Bus slave state
  logic waitReq_q, waitReq_d;
  logic [31:0] rdata_q, rdata_d;
  logic wrTake;
  logic reqSeen;

  // Control and settle state
  logic [4:0] ctrlMult_q, ctrlMult_d;
  logic ctrlBypass_q, ctrlBypass_d;
  logic [1:0] ctrlSsel_q, ctrlSsel_d;
  logic [1:0] ctrlReq_q, ctrlReq_d;
  logic [15:0] settle_q, settle_d;
  logic [15:0] settleCnt_q, settleCnt_d;
  logic [4:0] actMult_q, actMult_d;
  logic [1:0] actSsel_q, actSsel_d;

  // Mode state
  pmcc_pkg::pmcc_mode_type mode_q, mode_d;
  logic [1:0] bootCnt_q, bootCnt_d;
  logic idle_q, idle_d;
  logic pllOn_q, pllOn_d;
  logic bypassOut_q, bypassOut_d;
  logic dma_q, dma_d;
  logic regOk_q, regOk_d;
  logic idleRise;
  logic locked;
  logic fieldWrite;
  pmcc_pkg::pmcc_clk_cfg_type clkCfg;
  logic coreTick, sysTick;

  // Avalon-MM: one wait cycle, then answer
  always_comb begin
    reqSeen = avs_read | avs_write;
    waitReq_d = 1'b1;
    if (reqSeen && waitReq_q) begin
      waitReq_d = 1'b0;
    end
    wrTake = avs_write & ~waitReq_q;
    rdata_d = rdata_q;
    if (avs_read && waitReq_q) begin
      case (avs_address)
        pmcc_pkg::OFF_CTRL: begin
          rdata_d = 32'h0000_0000;
          rdata_d[pmcc_pkg::CTRL_MULT_LSB +: pmcc_pkg::CTRL_MULT_W] = ctrlMult_q;
          rdata_d[pmcc_pkg::CTRL_BYPASS_BIT] = ctrlBypass_q;
          rdata_d[pmcc_pkg::CTRL_SSEL_LSB +: 2] = ctrlSsel_q;
          rdata_d[pmcc_pkg::CTRL_REQ_LSB +: 2] = ctrlReq_q;
        end
        pmcc_pkg::OFF_SETTLE: begin
          rdata_d = {16'h0000, settle_q};
        end
        pmcc_pkg::OFF_STATUS: begin
          rdata_d = 32'h0000_0000;
          rdata_d[pmcc_pkg::STAT_MODE_LSB +: 6] = mode_q;
          rdata_d[pmcc_pkg::STAT_LOCK_BIT] = locked;
          rdata_d[pmcc_pkg::STAT_DMA_BIT] = dma_q;
          rdata_d[pmcc_pkg::STAT_MULT_LSB +: pmcc_pkg::CTRL_MULT_W] = actMult_q;
          rdata_d[pmcc_pkg::STAT_SSEL_LSB +: 2] = actSsel_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      waitReq_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      waitReq_q <= waitReq_d;
      rdata_q <= rdata_d;
    end
  end

  // Idle handshake: rises only once the system acknowledges
  always_comb begin
    idle_d = coreIdleReq & (sysAck | idle_q);
    idleRise = idle_d & ~idle_q;
  end

  // Mode sequencing
  always_comb begin
    mode_d = mode_q;
    bootCnt_d = bootCnt_q;
    case (mode_q)
      pmcc_pkg::MODE_BOOT: begin
        if (bootCnt_q == pmcc_pkg::BOOT_WAIT) begin
          mode_d = bypassS ? pmcc_pkg::MODE_ACTIVE : pmcc_pkg::MODE_FULL;
        end else begin
          bootCnt_d = bootCnt_q + 2'h1;
        end
      end
      pmcc_pkg::MODE_FULL, pmcc_pkg::MODE_ACTIVE, pmcc_pkg::MODE_RELAXED: begin
        if (idleRise) begin
          case (ctrlReq_q)
            pmcc_pkg::REQ_RELAX: mode_d = pmcc_pkg::MODE_RELAXED;
            pmcc_pkg::REQ_SLEEP: mode_d = pmcc_pkg::MODE_SLEEP;
            pmcc_pkg::REQ_DEEP: mode_d = pmcc_pkg::MODE_DEEP;
            default: mode_d = ctrlBypass_q ? pmcc_pkg::MODE_ACTIVE : pmcc_pkg::MODE_FULL;
          endcase
        end
      end
      pmcc_pkg::MODE_SLEEP: begin
        if (irqS) begin
          mode_d = ctrlBypass_q ? pmcc_pkg::MODE_ACTIVE : pmcc_pkg::MODE_FULL;
        end
      end
      pmcc_pkg::MODE_DEEP: begin
        // Only the real-time clock wakes; reset acts through rst
        if (rtcS) begin
          mode_d = pmcc_pkg::MODE_FULL;
        end
      end
      default: begin
        mode_d = pmcc_pkg::MODE_BOOT;
      end
    endcase
  end

  // Control and settle registers, boot strap capture and wake request clear
  always_comb begin
    ctrlMult_d = ctrlMult_q;
    ctrlBypass_d = ctrlBypass_q;
    ctrlSsel_d = ctrlSsel_q;
    ctrlReq_d = ctrlReq_q;
    settle_d = settle_q;
    fieldWrite = 1'b0;
    if (wrTake && avs_address == pmcc_pkg::OFF_CTRL) begin
      ctrlMult_d = avs_writedata[pmcc_pkg::CTRL_MULT_LSB +: pmcc_pkg::CTRL_MULT_W];
      ctrlBypass_d = avs_writedata[pmcc_pkg::CTRL_BYPASS_BIT];
      ctrlSsel_d = avs_writedata[pmcc_pkg::CTRL_SSEL_LSB +: 2];
      ctrlReq_d = avs_writedata[pmcc_pkg::CTRL_REQ_LSB +: 2];
      fieldWrite = (ctrlMult_d != ctrlMult_q) | (ctrlSsel_d != ctrlSsel_q);
    end
    if (wrTake && avs_address == pmcc_pkg::OFF_SETTLE) begin
      settle_d = avs_writedata[pmcc_pkg::SETTLE_W-1:0];
    end
    if (mode_q == pmcc_pkg::MODE_BOOT && bootCnt_q == pmcc_pkg::BOOT_WAIT) begin
      ctrlSsel_d = sselS;
      ctrlBypass_d = bypassS;
    end
    // A wake returns the request to run; it wins over a same-cycle write
    if ((mode_q == pmcc_pkg::MODE_SLEEP && irqS) || (mode_q == pmcc_pkg::MODE_DEEP && rtcS)) begin
      ctrlReq_d = pmcc_pkg::REQ_RUN;
    end
  end

  // PLL power and settle count
  always_comb begin
    case (mode_d)
      pmcc_pkg::MODE_FULL, pmcc_pkg::MODE_ACTIVE: pllOn_d = 1'b1;
      default: pllOn_d = 1'b0;
    endcase
    settleCnt_d = settleCnt_q;
    actMult_d = actMult_q;
    actSsel_d = actSsel_q;
    if (mode_q == pmcc_pkg::MODE_BOOT) begin
      actSsel_d = ctrlSsel_d;
      settleCnt_d = settle_q;
    end else if (fieldWrite || (pllOn_d && !pllOn_q)) begin
      settleCnt_d = settle_q;
    end else if (settleCnt_q != 16'h0000) begin
      settleCnt_d = settleCnt_q - 16'h0001;
    end else begin
      actMult_d = ctrlMult_q;
      actSsel_d = ctrlSsel_q;
    end
  end

  assign locked = pllOn_q & (settleCnt_q == 16'h0000);

  // Clock gating per mode
  always_comb begin
    clkCfg.ratioSel = actSsel_q;
    clkCfg.coreRun = 1'b0;
    clkCfg.sysRun = 1'b0;
    clkCfg.halfRate = 1'b1;
    bypassOut_d = 1'b1;
    case (mode_q)
      pmcc_pkg::MODE_FULL: begin
        clkCfg.coreRun = 1'b1;
        clkCfg.sysRun = 1'b1;
        // Input clock until settled; bypass in the same cycle as the PLL powers down
        clkCfg.halfRate = ~locked;
        bypassOut_d = ~locked | (mode_d != pmcc_pkg::MODE_FULL);
      end
      pmcc_pkg::MODE_ACTIVE, pmcc_pkg::MODE_RELAXED: begin
        clkCfg.coreRun = 1'b1;
        clkCfg.sysRun = 1'b1;
      end
      pmcc_pkg::MODE_SLEEP: begin
        clkCfg.sysRun = 1'b1;
      end
      pmcc_pkg::MODE_DEEP: begin
        clkCfg.sysRun = 1'b0;
      end
      default: begin
        clkCfg.sysRun = 1'b0;
      end
    endcase
    regOk_d = (mode_d == pmcc_pkg::MODE_DEEP);
    // DMA follows the next mode, in step with the regulator flag
    case (mode_d)
      pmcc_pkg::MODE_FULL, pmcc_pkg::MODE_ACTIVE, pmcc_pkg::MODE_RELAXED: begin
        dma_d = 1'b1;
      end
      default: dma_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrlMult_q <= MULT_DEFAULT;
      ctrlBypass_q <= 1'b0;
      ctrlSsel_q <= 2'h0;
      ctrlReq_q <= pmcc_pkg::REQ_RUN;
      settle_q <= SETTLE_DEFAULT;
      settleCnt_q <= SETTLE_DEFAULT;
      actMult_q <= MULT_DEFAULT;
      actSsel_q <= 2'h0;
      mode_q <= pmcc_pkg::MODE_BOOT;
      bootCnt_q <= 2'h0;
      idle_q <= 1'b0;
      pllOn_q <= 1'b0;
      bypassOut_q <= 1'b1;
      dma_q <= 1'b0;
      regOk_q <= 1'b0;
    end else begin
      ctrlMult_q <= ctrlMult_d;
      ctrlBypass_q <= ctrlBypass_d;
      ctrlSsel_q <= ctrlSsel_d;
      ctrlReq_q <= ctrlReq_d;
      settle_q <= settle_d;
      settleCnt_q <= settleCnt_d;
      actMult_q <= actMult_d;
      actSsel_q <= actSsel_d;
      mode_q <= mode_d;
      bootCnt_q <= bootCnt_d;
      idle_q <= idle_d;
      pllOn_q <= pllOn_d;
      bypassOut_q <= bypassOut_d;
      dma_q <= dma_d;
      regOk_q <= regOk_d;
    end
  end

  pmcc_clk_divider u_div (
    .clk(ref_clk),
    .rst(rst),
    .cfgIn(clkCfg),
    .coreTick(coreTick),
    .sysTick(sysTick)
  );

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = waitReq_q;
  assign idleOut = idle_q;
  assign coreClkEn = coreTick;
  assign sysClkEn = sysTick;
  assign pllEnable = pllOn_q;
  assign pllBypass = bypassOut_q;
  assign pllMult = actMult_q;
  assign dmaL1Allowed = dma_q;
  assign regulatorOk = regOk_q;

endmodule // power_mode_clock_controller
`default_nettype wire

// ===== verif/pmcc_asserts.sv
// Port checks of the power mode clock controller
`timescale 1ns/1ps
`default_nettype none
module pmcc_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic rtcWakeIrq,
  input wire logic coreIdleReq,
  input wire logic sysAck,
  input wire logic idleOut,
  input wire logic coreClkEn,
  input wire logic sysClkEn,
  input wire logic pllEnable,
  input wire logic pllBypass,
  input wire logic [4:0] pllMult,
  input wire logic dmaL1Allowed,
  input wire logic regulatorOk
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic [4:0] deepCnt_q;
  logic [4:0] deepCnt_d;
  logic [4:0] offCnt_q;
  logic [4:0] offCnt_d;
  logic [5:0] rtcHist_q;
  logic [5:0] rtcHist_d;
  // Saturating run lengths, recent wake history
  always_comb begin
    deepCnt_d = regulatorOk ? deepCnt_q + {4'h0, deepCnt_q != 5'h10} : 5'h00;
    offCnt_d = dmaL1Allowed ? 5'h00 : offCnt_q + {4'h0, offCnt_q != 5'h10};
    rtcHist_d = {rtcHist_q[4:0], rtcWakeIrq};
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      deepCnt_q <= 5'h00;
      offCnt_q <= 5'h00;
      rtcHist_q <= 6'h00;
    end else begin
      deepCnt_q <= deepCnt_d;
      offCnt_q <= offCnt_d;
      rtcHist_q <= rtcHist_d;
    end
  end
  property p_full_pll; !pllBypass |-> pllEnable; endproperty
  a_full_pll: assert property (p_full_pll) else $error("PLL off unbypassed");
  property p_relax; dmaL1Allowed && !pllEnable |-> pllBypass; endproperty
  a_relax: assert property (p_relax) else $error("PLL off not bypassed");
  property p_settle; $changed(pllMult) |-> !$past(avs_write && !avs_waitrequest); endproperty
  a_settle: assert property (p_settle) else $error("Multiplier skipped settle");
  property p_deep_gate; regulatorOk |-> !dmaL1Allowed && !pllEnable; endproperty
  a_deep_gate: assert property (p_deep_gate) else $error("Deep sleep not gated");
  property p_deep_clk; deepCnt_q == 5'h10 |-> !coreClkEn && !sysClkEn; endproperty
  a_deep_clk: assert property (p_deep_clk) else $error("Clock in deep sleep");
  property p_core_off; offCnt_q == 5'h10 |-> !coreClkEn; endproperty
  a_core_off: assert property (p_core_off) else $error("Core clock while idle");
  property p_deep_exit;
    $fell(regulatorOk) |-> (|rtcHist_q) && dmaL1Allowed && pllEnable;
  endproperty
  a_deep_exit: assert property (p_deep_exit) else $error("Bad deep exit");
  property p_idle_ack; $rose(idleOut) |-> $past(coreIdleReq) && $past(sysAck); endproperty
  a_idle_ack: assert property (p_idle_ack) else $error("Idle without ack");
  property p_idle_drop; !coreIdleReq |=> !idleOut; endproperty
  a_idle_drop: assert property (p_idle_drop) else $error("Idle held");
  property p_sys_gap; sysClkEn |=> !sysClkEn; endproperty
  a_sys_gap: assert property (p_sys_gap) else $error("System ratio below 2");
endmodule // pmcc_asserts
bind power_mode_clock_controller pmcc_asserts pmcc_asserts_i (
  .ref_clk(ref_clk), .rst(rst), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .rtcWakeIrq(rtcWakeIrq), .coreIdleReq(coreIdleReq), .sysAck(sysAck), .idleOut(idleOut),
  .coreClkEn(coreClkEn), .sysClkEn(sysClkEn), .pllEnable(pllEnable), .pllBypass(pllBypass),
  .pllMult(pllMult), .dmaL1Allowed(dmaL1Allowed), .regulatorOk(regulatorOk)
);
`default_nettype wire

// ===== verif/pmcc_partner_model.sv
// System acknowledge and interrupt source model
`timescale 1ns/1ps
`default_nettype none
module pmcc_partner_model (
  input wire logic ref_clk,
  input wire logic coreIdleReq,
  input wire logic irqCmd,
  input wire logic rtcCmd,
  output logic sysAck,
  output logic irqAny,
  output logic rtcWakeIrq
);
  int ackCnt;
  int ackDelay;
  initial begin
    sysAck = 1'b0;
    irqAny = 1'b0;
    rtcWakeIrq = 1'b0;
    ackCnt = 0;
    ackDelay = 1;
  end
  // No DMA traffic is ever issued from here
  always @(posedge ref_clk) begin
    irqAny <= irqCmd;
    rtcWakeIrq <= rtcCmd;
    if (!coreIdleReq) begin
      ackCnt <= 0;
      ackDelay <= $urandom_range(1, 4);
      sysAck <= 1'b0;
    end else begin
      ackCnt <= ackCnt + 1;
      sysAck <= (ackCnt == ackDelay);
    end
  end
endmodule // pmcc_partner_model
`default_nettype wire

// ===== verif/power_mode_clock_controller_test.sv
// Self-checking bench of the power mode clock controller
`timescale 1ns/1ps
`default_nettype none
module power_mode_clock_controller_test;
  localparam logic [31:0] MM = 32'h0000023F;
  localparam logic [31:0] MS = 32'h031F0000;
  logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, bypassPin, irqAny, rtcWakeIrq;
  logic coreIdleReq, sysAck, idleOut, coreClkEn, sysClkEn, pllEnable, pllBypass;
  logic dmaL1Allowed, regulatorOk, irqCmd, rtcCmd;
  logic [3:0] avs_address;
  logic [1:0] sselStrapPin, ssel;
  logic [4:0] pllMult, mult;
  logic [31:0] avs_writedata, avs_readdata, prev, e, m;
  logic [31:0] expQ[$], maskQ[$];
  int mismatches, comparisons;
  power_mode_clock_controller power_mode_clock_controller_i (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bypassPin(bypassPin), .sselStrapPin(sselStrapPin),
    .irqAny(irqAny), .rtcWakeIrq(rtcWakeIrq), .coreIdleReq(coreIdleReq), .sysAck(sysAck),
    .idleOut(idleOut), .coreClkEn(coreClkEn), .sysClkEn(sysClkEn), .pllEnable(pllEnable),
    .pllBypass(pllBypass), .pllMult(pllMult), .dmaL1Allowed(dmaL1Allowed),
    .regulatorOk(regulatorOk)
  );
  pmcc_partner_model pmcc_partner_model_i (
    .ref_clk(ref_clk), .coreIdleReq(coreIdleReq), .irqCmd(irqCmd), .rtcCmd(rtcCmd),
    .sysAck(sysAck), .irqAny(irqAny), .rtcWakeIrq(rtcWakeIrq)
  );
  function automatic logic [31:0] st(input logic [5:0] md);
    st = {22'h0, (md & 6'h0E) != 6'h00, 3'h0, md};
  endfunction
  function automatic logic [31:0] ms();
    ms = {6'h0, ssel, 3'h0, mult, 16'h0};
  endfunction
  function automatic logic [31:0] ctl(input logic [1:0] r, input logic b);
    ctl = {22'h0, r, ssel, b, mult};
  endfunction
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic chk(input logic [3:0] a, input logic [31:0] mk, input logic [31:0] ex);
    expQ.push_back(ex);
    maskQ.push_back(mk);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic chkmode(input logic [5:0] md);
    chk(pmcc_pkg::OFF_STATUS, MM, st(md));
  endtask
  task automatic go_idle();
    coreIdleReq <= 1'b1;
    @(posedge ref_clk);
    while (idleOut !== 1'b1) @(posedge ref_clk);
    coreIdleReq <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic mode_to(input logic [1:0] r, input logic b, input logic [5:0] md);
    bus(1'b1, pmcc_pkg::OFF_CTRL, ctl(r, b));
    go_idle();
    chkmode(md);
  endtask
  task automatic wake(input logic rtc);
    rtcCmd <= rtc;
    irqCmd <= !rtc;
    repeat (8) @(posedge ref_clk);
    rtcCmd <= 1'b0;
    irqCmd <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  // Counts system ticks over 60 core ticks
  task automatic ratio_chk(input int want);
    int core;
    int sys;
    core = 0;
    sys = 0;
    @(posedge ref_clk);
    while (coreClkEn !== 1'b1) @(posedge ref_clk);
    while (core < 60) begin
      @(posedge ref_clk);
      core += int'(coreClkEn);
      sys += int'(sysClkEn);
    end
    comparisons++;
    if (sys != want) begin
      mismatches++;
      $display("BAD sysClkEn count expected %0d seen %0d", want, sys);
    end
  endtask
  task automatic rst_cycle();
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Answer watcher: oldest note against each read result
  always @(posedge ref_clk) begin
    if (!rst && avs_read && avs_waitrequest === 1'b0) begin
      e = expQ.pop_front();
      m = maskQ.pop_front();
      comparisons++;
      if ((avs_readdata & m) !== e) begin
        mismatches++;
        $display("BAD readdata expected %h seen %h", e, avs_readdata & m);
      end
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(86309));
    {rst, avs_read, avs_write, bypassPin, irqCmd, rtcCmd, coreIdleReq} = 7'h40;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    mismatches = 0;
    comparisons = 0;
    ssel = 2'($urandom());
    sselStrapPin = ssel;
    mult = pmcc_pkg::MULT_RESET;
    rst_cycle();
    chk(pmcc_pkg::OFF_STATUS, MM | MS, st(pmcc_pkg::MODE_FULL) | ms());
    bus(1'b1, 4'hC, 32'hFFFFFFFF);
    chk(4'hC, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, pmcc_pkg::OFF_SETTLE, 32'h4);
    for (int b = 0; b < 2; b++) begin
      mode_to(pmcc_pkg::REQ_SLEEP, b[0], pmcc_pkg::MODE_SLEEP);
      wake(1'b0);
      chkmode(b ? pmcc_pkg::MODE_ACTIVE : pmcc_pkg::MODE_FULL);
    end
    mode_to(pmcc_pkg::REQ_RELAX, 1'b1, pmcc_pkg::MODE_RELAXED);
    for (int s = 0; s < 4; s++) begin
      prev = ms();
      ssel = 2'(s);
      mult = 5'($urandom_range(1, 31));
      bus(1'b1, pmcc_pkg::OFF_CTRL, ctl(pmcc_pkg::REQ_RELAX, 1'b1));
      chk(pmcc_pkg::OFF_STATUS, MS, prev);
      repeat (12) @(posedge ref_clk);
      chk(pmcc_pkg::OFF_STATUS, MS, ms());
      // Ratios 2, 2.5, 3, 4 to one give 30, 24, 20, 15 per 60 core ticks
      ratio_chk(s == 0 ? 30 : (s == 1 ? 24 : (s == 2 ? 20 : 15)));
    end
    chk(pmcc_pkg::OFF_CTRL, 32'h000003FF, ctl(pmcc_pkg::REQ_RELAX, 1'b1));
    mode_to(pmcc_pkg::REQ_RUN, 1'b0, pmcc_pkg::MODE_FULL);
    mode_to(pmcc_pkg::REQ_DEEP, 1'b1, pmcc_pkg::MODE_DEEP);
    wake(1'b0);
    chkmode(pmcc_pkg::MODE_DEEP);
    bypassPin <= 1'b1;
    wake(1'b1);
    chkmode(pmcc_pkg::MODE_FULL);
    mode_to(pmcc_pkg::REQ_DEEP, 1'b1, pmcc_pkg::MODE_DEEP);
    rst <= 1'b1;
    rst_cycle();
    chkmode(pmcc_pkg::MODE_ACTIVE);
    tally_and_finish();
  end
endmodule // power_mode_clock_controller_test
`default_nettype wire
